// ---- src/sbit_timer.sv ----
// sixteen-bit interval timer with AXI4-Lite register access
`timescale 1ns/1ps
`include "sbit_map.svh"

// Summary of operation
// - gate bit low stops all timer clocking
// - gate bit resets to zero
// - modes 000 and 001 select interval timing
// - run starts; mode and overflow writes blocked
// - clock select picks prescaled or slow source
// - counter increments once per source tick
// - match raises request, clears, keeps counting
// - clearing run halts and zeroes counter
// - low capture read latches high byte
// - stopped low read gives zero, clears high
// - capture enable active from start onward
// - run falling write keeps capture enable
// - low compare byte staged until high write
// - shadow enable bit turns buffering on
// - running shadow write loads at next match
// - buffered compare reads return shadow contents
// - stopped shadow write loads both at once
// - unbuffered compare write takes effect immediately
// - compare below count waits for wrap
module sbit_timer (
    // clock, reset, clock enable
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        clkEn,
    // slow clock pin
    input  wire logic        slowClkPin,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // match request
    output logic             matchIrq
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rstMeta_q;
    logic rstSync_b;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_b <= rstMeta_q;
        end
    end

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic        gateEn_q;
    logic [6:0]  mode_q;
    logic        run_q;
    logic        ove_q;
    logic        dbf_q;
    logic        acap_q;
    logic        dv9_q;
    logic        slowMode_q;
    logic [7:0]  stage_q;
    logic [15:0] shadow_q;
    logic [15:0] cmp_q;
    logic [15:0] count_q;
    logic [7:0]  capHigh_q;
    logic        irq_q;

    // ----------------------------------------------------------------
    // bus write channel
    // ----------------------------------------------------------------
    logic       awHeld_q;
    logic       wHeld_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic       bValid_q;
    logic       awReady_q;
    logic       wReady_q;
    logic       wrFire;
    logic       awTake;
    logic       wTake;
    logic       bValid_d;

    // readies are registered copies of the next free state
    assign awTake   = s_axi_awvalid && awReady_q;
    assign wTake    = s_axi_wvalid && wReady_q;
    assign wrFire   = awHeld_q && wHeld_q && !bValid_q;
    assign bValid_d = wrFire || (bValid_q && !s_axi_bready);

    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
            bValid_q <= 1'b0;
            awReady_q <= 1'b0;
            wReady_q  <= 1'b0;
        end else if (clkEn) begin
            awReady_q <= !bValid_d && !awHeld_q && !awTake;
            wReady_q  <= !bValid_d && !wHeld_q && !wTake;
            if (awTake) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (wTake) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
                bValid_q <= 1'b1;
            end else if (bValid_q && s_axi_bready) begin
                bValid_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awReady_q;
    assign s_axi_wready  = wReady_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = 2'b00;

    // write decode; only byte lane zero carries register data
    logic       lane0;
    logic       wrGate;
    logic       wrMode;
    logic       wrCtrl;
    logic       wrCmpL;
    logic       wrCmpH;
    logic       wrSys;
    logic [7:0] wByte;

    assign lane0  = wrFire && wStrb_q[0];
    assign wByte  = wData_q[7:0];
    assign wrGate = lane0 && awAddr_q == `SBIT_OFS_GATE;
    // until the gate is set, timer registers ignore writes
    assign wrMode = lane0 && gateEn_q && awAddr_q == `SBIT_OFS_MODE && !run_q;
    assign wrCtrl = lane0 && gateEn_q && awAddr_q == `SBIT_OFS_CTRL;
    assign wrCmpL = lane0 && gateEn_q && awAddr_q == `SBIT_OFS_CMPL;
    assign wrCmpH = lane0 && gateEn_q && awAddr_q == `SBIT_OFS_CMPH;
    assign wrSys  = lane0 && awAddr_q == `SBIT_OFS_SYS;

    // ----------------------------------------------------------------
    // bus read channel
    // ----------------------------------------------------------------
    logic        rValid_q;
    logic        arReady_q;
    logic [31:0] rData_q;
    logic [1:0]  rResp_q;
    logic        arTake;
    logic [7:0]  rdByte;
    logic        rdHit;
    logic        rdCapL;

    assign arTake = s_axi_arvalid && arReady_q;
    assign rdCapL = arTake && s_axi_araddr == `SBIT_OFS_CAPL && gateEn_q;
    assign rdHit  = s_axi_araddr == `SBIT_OFS_GATE || s_axi_araddr == `SBIT_OFS_MODE
                 || s_axi_araddr == `SBIT_OFS_CTRL || s_axi_araddr == `SBIT_OFS_CMPL
                 || s_axi_araddr == `SBIT_OFS_CMPH || s_axi_araddr == `SBIT_OFS_CAPL
                 || s_axi_araddr == `SBIT_OFS_CAPH || s_axi_araddr == `SBIT_OFS_SYS
                 || s_axi_araddr == `SBIT_OFS_COUNT;

    logic [15:0] cmpView;
    logic [7:0]  capLowView;

    assign cmpView    = dbf_q ? shadow_q : cmp_q;
    assign capLowView = run_q ? count_q[7:0] : 8'h00;

    // ctrl reads give bits 3 and 2 as zero
    always_comb begin
        unique case (s_axi_araddr)
            `SBIT_OFS_GATE:  rdByte = {7'h00, gateEn_q};
            `SBIT_OFS_MODE:  rdByte = {1'b0, mode_q};
            `SBIT_OFS_CTRL:  rdByte = {2'b00, acap_q, dbf_q, 2'b00, ove_q, run_q};
            `SBIT_OFS_CMPL:  rdByte = cmpView[7:0];
            `SBIT_OFS_CMPH:  rdByte = cmpView[15:8];
            `SBIT_OFS_CAPL:  rdByte = acap_q ? capLowView : 8'h00;
            `SBIT_OFS_CAPH:  rdByte = capHigh_q;
            `SBIT_OFS_SYS:   rdByte = {6'h00, slowMode_q, dv9_q};
            `SBIT_OFS_COUNT: rdByte = count_q[7:0];
            default:         rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            rValid_q <= 1'b0;
            arReady_q <= 1'b0;
            rData_q  <= 32'h0000_0000;
            rResp_q  <= 2'b00;
        end else if (clkEn) begin
            arReady_q <= !arTake && !(rValid_q && !s_axi_rready);
            if (arTake) begin
                rValid_q <= 1'b1;
                rData_q  <= (s_axi_araddr == `SBIT_OFS_COUNT) ? {16'h0000, count_q}
                                                              : {24'h000000, rdByte};
                rResp_q  <= rdHit ? 2'b00 : 2'b10;
            end else if (rValid_q && s_axi_rready) begin
                rValid_q <= 1'b0;
            end
        end
    end

    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic newRun;
    logic runFall;
    logic modeTimer;

    assign modeTimer = mode_q[6:5] == 2'b00;
    assign newRun  = wByte[`SBIT_CTRL_RUN_BIT];
    assign runFall = wrCtrl && run_q && !newRun;

    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            gateEn_q   <= 1'b0;
            mode_q     <= `SBIT_RST_MODE;
            run_q      <= 1'b0;
            ove_q      <= 1'b0;
            dbf_q      <= 1'b0;
            acap_q     <= 1'b0;
            dv9_q      <= 1'b0;
            slowMode_q <= 1'b0;
        end else if (clkEn) begin
            if (wrGate)
                gateEn_q <= wByte[`SBIT_GATE_EN_BIT];
            if (wrSys) begin
                dv9_q      <= wByte[`SBIT_SYS_DV9_BIT];
                slowMode_q <= wByte[`SBIT_SYS_SLOW_BIT];
            end
            if (wrMode)
                mode_q <= wByte[6:0];
            if (wrCtrl) begin
                run_q <= newRun && modeTimer;
                dbf_q <= wByte[`SBIT_CTRL_DBF_BIT];
                if (!run_q)
                    ove_q <= wByte[`SBIT_CTRL_OVE_BIT];
                if (!runFall)
                    acap_q <= wByte[`SBIT_CTRL_ACAP_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // counting
    // ----------------------------------------------------------------
    logic slowRise;
    logic tick;
    logic match;

    sbit_sync u_slowSync (
        .ref_clk   (ref_clk),
        .rstSync_b (rstSync_b),
        .clkEn     (clkEn),
        .pinIn     (slowClkPin),
        .level     (),
        .rise      (slowRise)
    );

    sbit_prescaler u_prescaler (
        .ref_clk    (ref_clk),
        .rstSync_b  (rstSync_b),
        .clkEn      (clkEn),
        .gateEn     (gateEn_q),
        .running    (run_q),
        .clkSel     (mode_q[`SBIT_MODE_CK_LSB +: 2]),
        .dividerOpt (dv9_q),
        .slowMode   (slowMode_q),
        .slowTick   (slowRise),
        .tick       (tick)
    );

    // match is judged on the counted value, so a smaller compare waits for wrap
    assign match = tick && (count_q == cmp_q);

    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            count_q <= 16'h0000;
            irq_q   <= 1'b0;
        end else if (clkEn && gateEn_q) begin
            irq_q <= match;
            if (!run_q || runFall)
                count_q <= 16'h0000;
            else if (match)
                count_q <= 16'h0000;
            else if (tick)
                count_q <= count_q + 16'h0001;
        end
    end

    assign matchIrq = irq_q;

    // ----------------------------------------------------------------
    // compare buffers and capture
    // ----------------------------------------------------------------
    logic [15:0] newCmp;

    assign newCmp = {wByte, stage_q};

    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            stage_q   <= 8'hff;
            shadow_q  <= `SBIT_RST_CMP;
            cmp_q     <= `SBIT_RST_CMP;
            capHigh_q <= `SBIT_RST_CAP;
        end else if (clkEn && gateEn_q) begin
            if (wrCmpL)
                stage_q <= wByte;
            if (wrCmpH)
                shadow_q <= newCmp;
            // a pending shadow still lands when a running write meets a match
            if (wrCmpH && (!dbf_q || !run_q))
                cmp_q <= newCmp;
            else if (match && dbf_q)
                cmp_q <= shadow_q;
            if (rdCapL && acap_q)
                capHigh_q <= run_q ? count_q[15:8] : 8'h00;
        end
    end

endmodule : sbit_timer

// ---- pkg/sbit_map.svh ----
// register offsets, field positions, reset values and prescaler divide exponents of the interval timer
`ifndef SBIT_MAP_SVH
`define SBIT_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SBIT_OFS_GATE      8'h00
`define SBIT_OFS_MODE      8'h04
`define SBIT_OFS_CTRL      8'h08
`define SBIT_OFS_CMPL      8'h0c
`define SBIT_OFS_CMPH      8'h10
`define SBIT_OFS_CAPL      8'h14
`define SBIT_OFS_CAPH      8'h18
`define SBIT_OFS_SYS       8'h1c
`define SBIT_OFS_COUNT     8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SBIT_GATE_EN_BIT   0
`define SBIT_MODE_CK_LSB   0
`define SBIT_MODE_M_LSB    4
`define SBIT_CTRL_RUN_BIT  0
`define SBIT_CTRL_OVE_BIT  1
`define SBIT_CTRL_DBF_BIT  4
`define SBIT_CTRL_ACAP_BIT 5
`define SBIT_SYS_DV9_BIT   0
`define SBIT_SYS_SLOW_BIT  1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SBIT_RST_CMP       16'hffff
`define SBIT_RST_CAP       8'hff
`define SBIT_RST_MODE      7'h00
`define SBIT_RST_CTRL      4'h0

// ----------------------------------------------------------------
// prescaler divide exponents
// ----------------------------------------------------------------
`define SBIT_DIV_00        10
`define SBIT_DIV_01        6
`define SBIT_DIV_10        2
`define SBIT_DIV_11        1
`define SBIT_DIV_SLOW      3

`endif

// ---- pkg/sbit_pkg.sv ----
// types of the interval timer
package sbit_pkg;

    typedef enum logic [1:0] {
        SBIT_CK_SLOWEST = 2'b00,
        SBIT_CK_DIV64   = 2'b01,
        SBIT_CK_DIV4    = 2'b10,
        SBIT_CK_DIV2    = 2'b11
    } sbit_clk_sel_t;

    typedef enum logic [1:0] {
        SBIT_BUS_IDLE = 2'b00,
        SBIT_BUS_RESP = 2'b01
    } sbit_bus_state_t;

endpackage : sbit_pkg

// ---- src/sbit_prescaler.sv ----
// prescaler that turns the gear and slow clocks into one counting tick
`timescale 1ns/1ps
`include "sbit_map.svh"

module sbit_prescaler (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstSync_b,
    input  wire logic       clkEn,
    // control
    input  wire logic       gateEn,
    input  wire logic       running,
    input  wire logic [1:0] clkSel,
    input  wire logic       dividerOpt,
    input  wire logic       slowMode,
    input  wire logic       slowTick,
    // tick
    output logic            tick
);

    logic [9:0] div_q;
    logic       slowDivEdge;
    logic [2:0] slowCnt_q;
    logic       useSlow;
    logic       gearTick;

    // slow source: tick on every eighth slow edge
    assign slowDivEdge = slowTick && (slowCnt_q == 3'h7);
    assign useSlow     = slowMode || (dividerOpt && clkSel == sbit_pkg::SBIT_CK_SLOWEST);

    // gear exponent selects which carry of the divider ticks
    always_comb begin
        unique case (sbit_pkg::sbit_clk_sel_t'(clkSel))
            sbit_pkg::SBIT_CK_SLOWEST: gearTick = &div_q[`SBIT_DIV_00-1:0];
            sbit_pkg::SBIT_CK_DIV64:   gearTick = &div_q[`SBIT_DIV_01-1:0];
            sbit_pkg::SBIT_CK_DIV4:    gearTick = &div_q[`SBIT_DIV_10-1:0];
            sbit_pkg::SBIT_CK_DIV2:    gearTick = div_q[0];
        endcase
    end

    assign tick = gateEn && running && (useSlow ? slowDivEdge : gearTick);

    // divider held clear while stopped so the first interval is full
    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            div_q     <= 10'h000;
            slowCnt_q <= 3'h0;
        end else if (clkEn && gateEn) begin
            div_q     <= running ? div_q + 10'h001 : 10'h000;
            if (!running)
                slowCnt_q <= 3'h0;
            else if (slowTick)
                slowCnt_q <= slowCnt_q + 3'h1;
        end
    end

endmodule : sbit_prescaler

// ---- src/sbit_sync.sv ----
// three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/1ps

module sbit_sync (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rstSync_b,
    input  wire logic clkEn,
    // pin in, clean level and rising event out
    input  wire logic pinIn,
    output logic      level,
    output logic      rise
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic agree;

    assign agree = (s2_q == s3_q);
    assign level = level_q;
    assign rise  = agree && s2_q && !level_q;

    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_q <= 1'b0;
        end else if (clkEn) begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree)
                level_q <= s2_q;
        end
    end

endmodule : sbit_sync

// ---- sim/sbit_timer_sva.sv ----
// assertions on the register bus and match request of the interval timer
`timescale 1ns/1ps
`include "sbit_map.svh"

module sbit_timer_chk (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        clkEn,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // match request
    input wire logic        matchIrq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------------------------------
    // gate bit as last written
    // ----------------------------------------------------------------
    logic gateOn_q;
    logic gateOn_d;
    logic wrBoth;
    assign wrBoth = clkEn && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign gateOn_d = (wrBoth && s_axi_awaddr == `SBIT_OFS_GATE) ? s_axi_wdata[0] : gateOn_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) gateOn_q <= 1'b0;
        else gateOn_q <= gateOn_d;
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence wrTaken;
        wrBoth;
    endsequence
    sequence rdTaken;
        clkEn && s_axi_arvalid && s_axi_arready;
    endsequence

    AST_B_AFTER_WRITE: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_B_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
        else $error("write response not okay");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted with response pending");
    AST_R_AFTER_READ: assert property (rdTaken |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted with data pending");
    AST_IRQ_PULSE: assert property (matchIrq && clkEn |=> !matchIrq)
        else $error("match request longer than one cycle");
    AST_GATE_OFF_QUIET: assert property (!gateOn_q && !$past(gateOn_q, 2) |-> !matchIrq)
        else $error("match request while gated off");
endmodule : sbit_timer_chk

bind sbit_timer sbit_timer_chk u_sbit_timer_chk (
    .ref_clk, .rst_b, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .matchIrq
);

// ---- sim/testbench.sv ----
// self-checking bench of the interval timer
`timescale 1ns/1ps
`include "sbit_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
    // ----------------------------------------------------------------
    // stimulus and wiring
    // ----------------------------------------------------------------
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        clkEn = 1'b1;
    logic        slowClkPin = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        matchIrq;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int          fails = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          dv [6] = '{1024, 64, 4, 2, 112, 112};

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    // slow source: one rising edge every 14 cycles
    always begin
        repeat (7) @(posedge ref_clk);
        slowClkPin <= ~slowClkPin;
    end

    sbit_timer u_sbit_timer (
        .ref_clk, .rst_b, .clkEn, .slowClkPin,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .matchIrq
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic int period(input int div, input int n);
        return div * (n + 1);
    endfunction : period

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            fails++;
            report_and_stop();
        end
    endtask : tmo

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($urandom_range(0, 1));
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        tmo(n, 50);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom_range(0, 1));
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            s_axi_rready <= 1'b1;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(n, 50);
    endtask : axi_rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        `CHK(d, e)
    endtask : rdc

    task automatic wait_irq(output int t);
        int n;
        for (n = 0; n < 20000; n++) begin
            @(posedge ref_clk);
            if (matchIrq === 1'b1) break;
        end
        t = cyc;
        tmo(n, 20000);
    endtask : wait_irq

    // first request may end mid-period, so only the second gap counts
    task automatic measure(input int e);
        int t0, t1;
        wait_irq(t0);
        wait_irq(t1);
        `CHK(t1 - t0, e)
    endtask : measure

    task automatic set_cmp(input int v);
        axi_wr(`SBIT_OFS_CMPL, 32'(v & 8'hff));
        axi_wr(`SBIT_OFS_CMPH, 32'(v >> 8));
    endtask : set_cmp

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        int i, n, n2, t0, t1, t2, ck;
        logic [31:0] d, b, h, l;
        logic [1:0]  r;
        void'($urandom(82191));
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rdc(`SBIT_OFS_GATE, 32'h0);
        rdc(`SBIT_OFS_CAPH, 32'hff);
        rdc(`SBIT_OFS_COUNT, 32'h0);
        axi_wr(`SBIT_OFS_CTRL, 32'h1);
        rdc(`SBIT_OFS_CTRL, 32'h0);
        axi_rd(8'h3c, d, r);
        `CHK(r, 2'b10)
        `CHK(d, 32'h0)
        axi_wr(`SBIT_OFS_GATE, 32'h1);
        rdc(`SBIT_OFS_GATE, 32'h1);
        for (i = 0; i < 6; i++) begin
            n = $urandom_range(1, 3);
            ck = (i < 4) ? i : 0;
            // last two passes: divider option, then slow mode
            axi_wr(`SBIT_OFS_SYS, 32'(i == 4) | (32'(i == 5) << 1));
            axi_wr(`SBIT_OFS_MODE, 32'(($urandom_range(0, 1) << 4) | ck));
            set_cmp(n);
            axi_wr(`SBIT_OFS_CTRL, 32'h1);
            measure(period(dv[i], n));
            axi_wr(`SBIT_OFS_MODE, 32'(ck ^ 1));
            axi_wr(`SBIT_OFS_CTRL, 32'h3);
            measure(period(dv[i], n));
            rdc(`SBIT_OFS_CTRL, 32'h1);
            axi_wr(`SBIT_OFS_CTRL, 32'h0);
            rdc(`SBIT_OFS_COUNT, 32'h0);
        end
        axi_wr(`SBIT_OFS_SYS, 32'h0);
        axi_wr(`SBIT_OFS_MODE, 32'h3);
        set_cmp(16'hffff);
        axi_wr(`SBIT_OFS_CTRL, 32'h21);
        repeat (600) @(posedge ref_clk);
        axi_rd(`SBIT_OFS_COUNT, b, r);
        axi_rd(`SBIT_OFS_CAPL, l, r);
        axi_rd(`SBIT_OFS_CAPH, h, r);
        axi_rd(`SBIT_OFS_COUNT, d, r);
        `CHK({h[7:0], l[7:0]} >= b && {h[7:0], l[7:0]} <= d, 1'b1)
        axi_wr(`SBIT_OFS_CTRL, 32'h0);
        rdc(`SBIT_OFS_CTRL, 32'h20);
        rdc(`SBIT_OFS_CAPH, h);
        rdc(`SBIT_OFS_CAPL, 32'h0);
        rdc(`SBIT_OFS_CAPH, 32'h0);
        n = $urandom_range(20, 40);
        n2 = n + $urandom_range(10, 20);
        axi_wr(`SBIT_OFS_CTRL, 32'h10);
        set_cmp(n);
        axi_wr(`SBIT_OFS_CTRL, 32'h11);
        rdc(`SBIT_OFS_CTRL, 32'h11);
        measure(period(2, n));
        wait_irq(t0);
        axi_wr(`SBIT_OFS_CMPL, 32'(n2));
        rdc(`SBIT_OFS_CMPL, 32'(n));
        axi_wr(`SBIT_OFS_CMPH, 32'h0);
        rdc(`SBIT_OFS_CMPL, 32'(n2));
        wait_irq(t1);
        wait_irq(t2);
        `CHK(t1 - t0, period(2, n))
        `CHK(t2 - t1, period(2, n2))
        axi_wr(`SBIT_OFS_CTRL, 32'h1);
        wait_irq(t0);
        set_cmp(n);
        wait_irq(t1);
        `CHK(t1 - t0, period(2, n))
        // clock enable low freezes prescaler and counter alike
        clkEn <= 1'b0;
        repeat (37) @(posedge ref_clk);
        clkEn <= 1'b1;
        wait_irq(t2);
        `CHK(t2 - t1, period(2, n) + 37)
        report_and_stop();
    end
endmodule : testbench
